/* rtl/spi_data_fifo_port.sv */
// Serial port data path: Avalon-MM register file, transmit and receive
// FIFOs behind the data word, and a slave shift engine on the pins.
// Assumes pins are asynchronous to clk and sck is far slower than clk.
//
// Behaviour
// - Data word at 0x0C, zero after reset
// - Data read returns oldest receive entry
// - Data write goes into transmit FIFO
// - Frames are 8 or 16 bits by select
// - Narrow frames use low byte, right aligned
// - Narrow receive reads upper byte as zero
// - Wide frames use all sixteen bits
// - Width select resets zero; one means wide
// - Fill levels coded empty, up to quarter, up to half, above half
// - Transmit empty flag set while FIFO empty
// - Receive pending flag set while entries wait
`timescale 1ns/10ps
`include "spi_port_map.svh"

module word_fifo #(
   parameter int W  = 16,
   parameter int D  = 4,
   parameter int AW = $clog2(D)
) (
   input  wire logic          clk,   // Core clock
   input  wire logic          reset, // Sync reset
   input  wire logic          push,  // Append din
   input  wire logic [W-1:0]  din,   // Entry in
   input  wire logic          pop,   // Drop head
   output logic       [W-1:0] dout,  // Head entry
   output logic       [AW:0]  count  // Entries held
);
   logic [W-1:0]  mem [D];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic          do_push, do_pop;

   always_comb begin
      do_push = push && (cnt_q != (AW+1)'(D));
      do_pop  = pop && (cnt_q != '0);
      wr_d    = wr_q;
      rd_d    = rd_q;
      if (do_push) wr_d = (wr_q == AW'(D-1)) ? '0 : wr_q + AW'(1);
      if (do_pop) rd_d = (rd_q == AW'(D-1)) ? '0 : rd_q + AW'(1);
      cnt_d = cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage needs no reset; empty is tracked by the count
   always_ff @(posedge clk) begin
      if (do_push) mem[wr_q] <= din;
   end

   assign dout  = mem[rd_q];
   assign count = cnt_q;
endmodule : word_fifo

////////////////////////////////////////////////////////////////////////////////

module spi_data_fifo_port
   import spi_port_pkg::*;
#(
   parameter int DEPTH = 4
) (
   input  wire logic        clk,         // 20 MHz core clock
   input  wire logic        reset,       // Sync reset, high
   input  wire logic [4:0]  address,     // Byte address
   input  wire logic        read,        // Avalon read
   input  wire logic        write,       // Avalon write
   input  wire logic [31:0] writedata,   // Avalon write data
   input  wire logic [3:0]  byteenable,  // Avalon byte lanes
   output logic      [31:0] readdata,    // Avalon read data
   output logic             waitrequest, // Avalon stall
   output logic             irq,         // Level interrupt
   input  wire logic        sck,         // Serial clock pin
   input  wire logic        mosi,        // Serial data in pin
   input  wire logic        cs_n,        // Chip select pin, low
   output logic             miso,        // Serial data out
   output logic             miso_oe      // Drive enable for miso
);
   localparam int CW = $clog2(DEPTH) + 1;

   logic [15:0] ctl1_q, ctl1_d, ctl2_q, ctl2_d, rd_word;
   logic [2:0]  irq_st_q, irq_st_d, mask_q, mask_d, clr, ev;
   logic        wait_q, wait_d, irq_q, irq_d;
   logic [31:0] rdata_q, rdata_d;
   pins_t       pin_m_q, pin_s_q;
   logic        sck_prev_q, sel_prev_q;
   logic [15:0] rx_sh_q, rx_sh_d, tx_sh_q, tx_sh_d;
   logic [4:0]  cnt_q, cnt_d, last;
   logic        miso_q, miso_d, oe_q, oe_d;
   logic        pre_q, pre_d;  // Next word already fetched into shifter
   logic        act, sel_c1, sel_c2, sel_st, sel_data, sel_ist, sel_msk;
   logic        narrow, sel, start, rise, fall, sck_eff;
   logic        tx_push, tx_pop, rx_push, rx_pop;
   logic [15:0] tx_din, tx_dout, tx_head, rx_din, rx_dout;
   logic [CW-1:0] tx_cnt, rx_cnt;
   status_t     st;

   word_fifo #(.W(16), .D(DEPTH)) tx_fifo (
      .clk   (clk),
      .reset (reset),
      .push  (tx_push),
      .din   (tx_din),
      .pop   (tx_pop),
      .dout  (tx_dout),
      .count (tx_cnt)
   );

   word_fifo #(.W(16), .D(DEPTH)) rx_fifo (
      .clk   (clk),
      .reset (reset),
      .push  (rx_push),
      .din   (rx_din),
      .pop   (rx_pop),
      .dout  (rx_dout),
      .count (rx_cnt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register bus: one wait cycle, then a single-cycle acknowledge

   assign act      = (read | write) & wait_q;
   assign sel_c1   = address == `OFF_CONTROL_ONE;
   assign sel_c2   = address == `OFF_CONTROL_TWO;
   assign sel_st   = address == `OFF_STATUS_FLAGS;
   assign sel_data = address == `OFF_DATA_WORD;
   assign sel_ist  = address == `OFF_IRQ_STATUS;
   assign sel_msk  = address == `OFF_IRQ_MASK;
   assign narrow   = ~ctl2_q[`BIT_FRAME_WIDTH];
   assign last     = narrow ? `LAST_BIT_NARROW : `LAST_BIT_WIDE;
   assign tx_din   = narrow ? {8'h00, writedata[7:0]} : writedata[15:0];
   assign tx_head  = (tx_cnt != '0) ? tx_dout : 16'h0000;

   always_comb begin
      st                 = '0;
      st.tx_fill_level   = fill_code(int'(tx_cnt), DEPTH);
      st.rx_fill_level   = fill_code(int'(rx_cnt), DEPTH);
      st.busy            = sel_prev_q | (tx_cnt != '0);
      st.overrun         = irq_st_q[`IRQ_OVERRUN];
      st.tx_empty_flag   = tx_cnt == '0;
      st.rx_pending_flag = rx_cnt != '0;
   end

   always_comb begin
      case (address)
         `OFF_CONTROL_ONE:  rd_word = ctl1_q;
         `OFF_CONTROL_TWO:  rd_word = ctl2_q;
         `OFF_STATUS_FLAGS: rd_word = st;
         // Empty FIFO reads zero, so a fresh reset shows zero
         `OFF_DATA_WORD:    rd_word = (rx_cnt != '0) ? rx_dout : `RST_DATA_WORD;
         `OFF_IRQ_STATUS:   rd_word = {13'h0000, irq_st_q};
         `OFF_IRQ_MASK:     rd_word = {13'h0000, mask_q};
         default:           rd_word = 16'h0000;
      endcase
   end

   always_comb begin
      ctl1_d  = ctl1_q;
      ctl2_d  = ctl2_q;
      mask_d  = mask_q;
      clr     = '0;
      wait_d  = ~act;
      rdata_d = rdata_q;
      tx_push = act & write & sel_data & (|byteenable[1:0]);
      rx_pop  = act & read & sel_data;
      if (act & write & byteenable[0]) begin
         if (sel_c1) ctl1_d[7:0] = writedata[7:0] & 8'(`CTL1_RW_MASK);
         if (sel_c2) ctl2_d[7:0] = writedata[7:0] & 8'(`CTL2_RW_MASK);
         if (sel_msk) mask_d = writedata[2:0];
         if (sel_ist) clr = writedata[2:0];
      end
      if (act & write & byteenable[1]) begin
         if (sel_c1) ctl1_d[15:8] = writedata[15:8] & 8'(`CTL1_RW_MASK >> 8);
         if (sel_c2) ctl2_d[15:8] = writedata[15:8] & 8'(`CTL2_RW_MASK >> 8);
      end
      if (act & read) rdata_d = {16'h0000, rd_word};
      // Set wins over a same-cycle clear
      irq_st_d = (irq_st_q & ~clr) | ev;
      irq_d    = |(irq_st_q & mask_q);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial slave engine; MSB first, data sampled on the leading edge

   assign sck_eff = pin_s_q.sck ^ ctl1_q[`BIT_CPOL];
   assign sel     = ~pin_s_q.cs_n & ctl1_q[`BIT_ENABLE];
   assign start   = sel & ~sel_prev_q;
   assign rise    = sel & ~start & sck_eff & ~sck_prev_q;
   assign fall    = sel & ~start & ~sck_eff & sck_prev_q;
   assign rx_din  = narrow ? {8'h00, rx_sh_d[7:0]} : rx_sh_d;

   always_comb begin
      rx_sh_d = rx_sh_q;
      tx_sh_d = tx_sh_q;
      cnt_d   = cnt_q;
      pre_d   = pre_q;
      tx_pop  = 1'b0;
      rx_push = 1'b0;
      if (!sel) begin
         cnt_d = '0;
      end else if (start) begin
         // A word fetched at the end of the last frame is kept, not lost
         if (!pre_q) begin
            tx_sh_d = tx_head;
            tx_pop  = tx_cnt != '0;
         end
         pre_d = 1'b0;
         cnt_d = '0;
      end else if (rise) begin
         rx_sh_d = {rx_sh_q[14:0], pin_s_q.mosi};
         if (cnt_q == last) begin
            rx_push = 1'b1;
            cnt_d   = '0;
         end else begin
            cnt_d = cnt_q + 5'h01;
         end
      end else if (fall) begin
         // Count at zero means a frame just closed: fetch the next word
         if (cnt_q == '0) begin
            tx_sh_d = tx_head;
            tx_pop  = tx_cnt != '0;
            pre_d   = tx_cnt != '0;
         end else begin
            tx_sh_d = {tx_sh_q[14:0], 1'b0};
            pre_d   = 1'b0;
         end
      end
      miso_d = sel & (narrow ? tx_sh_d[7] : tx_sh_d[15]);
      oe_d   = sel;
   end

   // Overrun keeps the old entries; the new frame is lost
   assign ev[`IRQ_RX_FRAME]   = rx_push & (rx_cnt != CW'(DEPTH));
   assign ev[`IRQ_TX_DRAINED] = tx_pop & (tx_cnt == CW'(1)) & ~tx_push;
   assign ev[`IRQ_OVERRUN]    = rx_push & (rx_cnt == CW'(DEPTH));

   always_ff @(posedge clk) begin
      if (reset) begin
         ctl1_q     <= `RST_CONTROL;
         ctl2_q     <= `RST_CONTROL;
         mask_q     <= '0;
         irq_st_q   <= '0;
         wait_q     <= 1'b1;
         rdata_q    <= '0;
         irq_q      <= 1'b0;
         pin_m_q    <= '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};
         pin_s_q    <= '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};
         sck_prev_q <= 1'b0;
         sel_prev_q <= 1'b0;
         rx_sh_q    <= '0;
         tx_sh_q    <= '0;
         cnt_q      <= '0;
         pre_q      <= 1'b0;
         miso_q     <= 1'b0;
         oe_q       <= 1'b0;
      end else begin
         ctl1_q     <= ctl1_d;
         ctl2_q     <= ctl2_d;
         mask_q     <= mask_d;
         irq_st_q   <= irq_st_d;
         wait_q     <= wait_d;
         rdata_q    <= rdata_d;
         irq_q      <= irq_d;
         pin_m_q    <= '{cs_n: cs_n, sck: sck, mosi: mosi};
         pin_s_q    <= pin_m_q;
         sck_prev_q <= sck_eff;
         sel_prev_q <= sel;
         rx_sh_q    <= rx_sh_d;
         tx_sh_q    <= tx_sh_d;
         cnt_q      <= cnt_d;
         pre_q      <= pre_d;
         miso_q     <= miso_d;
         oe_q       <= oe_d;
      end
   end

   assign readdata    = rdata_q;
   assign waitrequest = wait_q;
   assign irq         = irq_q;
   assign miso        = miso_q;
   assign miso_oe     = oe_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_data_zero;
      act && read && sel_data && rx_cnt == '0 |=> readdata == 32'h0000_0000;
   endproperty
   a_data_zero: assert property (p_data_zero) else $error("empty data read not zero");

   property p_data_head;
      act && read && sel_data && rx_cnt != '0 |=> readdata[15:0] == $past(rx_dout) && !waitrequest;
   endproperty
   a_data_head: assert property (p_data_head) else $error("data read not FIFO head");

   property p_tx_push;
      act && write && sel_data && byteenable[0] && tx_cnt == '0 && !tx_pop |=> tx_cnt == CW'(1);
   endproperty
   a_tx_push: assert property (p_tx_push) else $error("data write not queued");

   property p_frame_len;
      rx_push |-> cnt_q == (ctl2_q[`BIT_FRAME_WIDTH] ? 5'h0F : 5'h07);
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

   property p_narrow_out;
      start && !pre_q && narrow && tx_cnt != '0 |=> miso_q == $past(tx_dout[7]) && miso_oe;
   endproperty
   a_narrow_out: assert property (p_narrow_out) else $error("narrow first bit wrong");

   property p_narrow_read;
      act && read && sel_data && narrow |=> readdata[15:8] == 8'h00;
   endproperty
   a_narrow_read: assert property (p_narrow_read) else $error("narrow upper byte set");

   property p_wide_out;
      start && !pre_q && !narrow && tx_cnt != '0 |=> miso_q == $past(tx_dout[15]);
   endproperty
   a_wide_out: assert property (p_wide_out) else $error("wide first bit wrong");

   property p_width_reset;
      $fell(reset) |-> ctl2_q[`BIT_FRAME_WIDTH] == 1'b0 && readdata == 32'h0000_0000;
   endproperty
   a_width_reset: assert property (p_width_reset) else $error("width select not reset");

   property p_levels;
      act && read && sel_st |=> readdata[12:9] == {fill_code(int'($past(tx_cnt)), DEPTH),
                                                   fill_code(int'($past(rx_cnt)), DEPTH)};
   endproperty
   a_levels: assert property (p_levels) else $error("fill level code wrong");

   property p_flags;
      act && read && sel_st |=> readdata[1] == ($past(tx_cnt) == '0) && readdata[0] == ($past(rx_cnt) != '0);
   endproperty
   a_flags: assert property (p_flags) else $error("empty or pending flag wrong");

   property p_rx_pop;
      act && read && sel_data && rx_cnt != '0 && !rx_push |=> rx_cnt == $past(rx_cnt) - CW'(1);
   endproperty
   a_rx_pop: assert property (p_rx_pop) else $error("data read did not pop");

   property p_ack;
      (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
   endproperty
   a_ack: assert property (p_ack) else $error("acknowledge not one cycle");

   c_wide_frame: cover property (rx_push && !narrow);
   c_tx_write: cover property (tx_push ##[1:400] tx_pop);
   c_irq: cover property ($rose(irq));
   c_overrun: cover property (ev[`IRQ_OVERRUN]);
endmodule : spi_data_fifo_port

/* pkg/spi_port_map.svh */
// Register offsets, field positions and reset values of the serial port.
// Included by the design file; holds definitions only.
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH
`define OFF_CONTROL_ONE  5'h00
`define OFF_CONTROL_TWO  5'h04
`define OFF_STATUS_FLAGS 5'h08
`define OFF_DATA_WORD    5'h0C
`define OFF_IRQ_STATUS   5'h10
`define OFF_IRQ_MASK     5'h14
`define RST_CONTROL      16'h0000
`define RST_DATA_WORD    16'h0000
`define CTL1_RW_MASK     16'hCFFF
`define CTL2_RW_MASK     16'h88E4
`define BIT_CPOL         1
`define BIT_ENABLE       6
`define BIT_FRAME_WIDTH  11
`define IRQ_RX_FRAME     0
`define IRQ_TX_DRAINED   1
`define IRQ_OVERRUN      2
`define LAST_BIT_NARROW  5'h07
`define LAST_BIT_WIDE    5'h0F
`endif

/* pkg/spi_port_pkg.sv */
// Types shared by the serial port design.
// Assumes the map header supplies the numeric constants.
package spi_port_pkg;
   typedef struct packed {
      logic cs_n;
      logic sck;
      logic mosi;
   } pins_t;

   typedef struct packed {
      logic [2:0] res_hi;
      logic [1:0] tx_fill_level;
      logic [1:0] rx_fill_level;
      logic       res_8;
      logic       busy;
      logic       overrun;
      logic       mode_fault;
      logic [2:0] res_lo;
      logic       tx_empty_flag;
      logic       rx_pending_flag;
   } status_t;

   function automatic logic [1:0] fill_code(input int cnt, input int depth);
      if (cnt == 0) return 2'h0;
      else if (cnt * 4 <= depth) return 2'h1;
      else if (cnt * 2 <= depth) return 2'h2;
      else return 2'h3;
   endfunction : fill_code
endpackage : spi_port_pkg

/* tb/spi_master_model.sv */
// Behavioural serial master standing on the far side of the port.
// Assumes the device is a mode 0 slave, MSB first; the bench calls xfer.
`timescale 1ns/10ps
module spi_master_model (
   output logic      sck,  // Serial clock, low between frames
   output logic      mosi, // Data to device
   output logic      cs_n, // Select, low
   input  wire logic miso  // Data from device
);
   initial begin
      sck  = 1'b0;
      mosi = 1'b1;
      cs_n = 1'b1;
   end

   task automatic xfer(input int nb, input logic [15:0] tx, output logic [15:0] rx);
      rx = 16'h0000;
      #13 cs_n = 1'b0;
      #400;
      for (int i = nb - 1; i >= 0; i--) begin
         mosi = tx[i];
         #200 sck = 1'b1;
         // Late in high phase: the device shifts only after the fall
         #200 rx = {rx[14:0], miso};
         sck = 1'b0;
      end
      #200 cs_n = 1'b1;
      mosi = ~mosi;
      // Idle gap so the deselect is seen before the next frame
      #400;
   endtask : xfer
endmodule : spi_master_model

/* tb/spi_data_fifo_port_test.sv */
// Self-checking bench for the serial port data path.
// Assumes the design files and the master model are compiled first.
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module spi_data_fifo_port_test;
   import spi_port_pkg::*;
   typedef struct packed {
      logic        w;
      logic [4:0]  a;
      logic [15:0] d;
      logic [15:0] e;
   } row_t;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [4:0]  address = 5'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        irq;
   logic        sck, mosi, cs_n, miso, miso_oe;
   logic [15:0] q, rx;
   int          n_errors = 0;
   int          checks = 0;
   // Released line shows the inverse, never a stale bit
   wire         miso_line = miso_oe ? miso : ~miso;
   row_t rows[15] = '{
      '{1'b0, 5'h00, 16'h0000, 16'h0000},
      '{1'b0, 5'h04, 16'h0000, 16'h0000},
      '{1'b0, 5'h08, 16'h0000, 16'h0002},
      '{1'b0, 5'h0C, 16'h0000, 16'h0000},
      '{1'b0, 5'h10, 16'h0000, 16'h0000},
      '{1'b0, 5'h14, 16'h0000, 16'h0000},
      '{1'b1, 5'h18, 16'hFFFF, 16'h0000},
      '{1'b0, 5'h18, 16'h0000, 16'h0000},
      '{1'b1, 5'h00, 16'hFFFF, 16'h0000},
      '{1'b0, 5'h00, 16'h0000, 16'hCFFF},
      '{1'b1, 5'h04, 16'hFFFF, 16'h0000},
      '{1'b0, 5'h04, 16'h0000, 16'h88E4},
      '{1'b1, 5'h04, 16'h0000, 16'h0000},
      '{1'b1, 5'h00, 16'h0040, 16'h0000},
      '{1'b0, 5'h08, 16'h0000, 16'h0002}
   };

   always #25 clk = ~clk;

   spi_data_fifo_port #(.DEPTH(4)) dut (
      .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq), .sck(sck), .mosi(mosi),
      .cs_n(cs_n), .miso(miso), .miso_oe(miso_oe)
   );
   spi_master_model master (.sck(sck), .mosi(mosi), .cs_n(cs_n), .miso(miso_line));

   ////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (n_errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test

   task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] r);
      int n;
      n = 0;
      address   <= a;
      writedata <= {16'h0000, d};
      write     <= w;
      read      <= ~w;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      r = readdata[15:0];
      // Busy timing is the designer's choice
      if (a == 5'h08)
         r[7] = 1'b0;
      write <= 1'b0;
      read  <= 1'b0;
      @(posedge clk);
      if (n >= 20) `CHK(waitrequest, 1'b0)
   endtask : bus

   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      logic [15:0] r;
      bus(1'b0, a, 16'h0000, r);
      `CHK(r, e)
   endtask : rd

   ////////////////////////////////////////////////////////////
   initial begin
      #200_000;
      n_errors++;
      end_of_test();
   end

   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      foreach (rows[i]) begin
         bus(rows[i].w, rows[i].a, rows[i].d, q);
         if (!rows[i].w) `CHK(q, rows[i].e)
      end
      bus(1'b1, 5'h0C, 16'h12A5, q);
      rd(5'h08, 16'h0800);
      for (int i = 1; i <= 4; i++)
         bus(1'b1, 5'h0C, 16'(i), q);
      rd(5'h08, 16'h1800);
      master.xfer(8, 16'h003C, rx);
      `CHK(rx, 16'h00A5)
      rd(5'h08, 16'h1201);
      bus(1'b1, 5'h14, 16'h0001, q);
      `CHK(irq, 1'b1)
      rd(5'h0C, 16'h003C);
      rd(5'h08, 16'h1000);
      bus(1'b1, 5'h10, 16'h0001, q);
      `CHK(irq, 1'b0)
      for (int i = 1; i <= 3; i++) begin
         master.xfer(8, 16'hFFC0 + 16'(i), rx);
         `CHK(rx, 16'(i))
      end
      rd(5'h08, 16'h0603);
      rd(5'h10, 16'h0003);
      bus(1'b1, 5'h14, 16'h0000, q);
      `CHK(irq, 1'b0)
      for (int i = 1; i <= 3; i++)
         rd(5'h0C, 16'h00C0 + 16'(i));
      rd(5'h0C, 16'h0000);
      bus(1'b1, 5'h04, 16'h0800, q);
      bus(1'b1, 5'h0C, 16'hBEEF, q);
      master.xfer(16, 16'h1234, rx);
      `CHK(rx, 16'hBEEF)
      rd(5'h0C, 16'h1234);
      bus(1'b1, 5'h0C, 16'h5555, q);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd(5'h04, 16'h0000);
      rd(5'h08, 16'h0002);
      end_of_test();
   end
endmodule : spi_data_fifo_port_test
